// [hdl/cs_corr_cmd.sv]
// correction-settings command block: sweep floor, open/short/load switches, answers
// assumes command strobes and characters come from logic on mclk
// How it works
// - floor accepted 1 mHz to 1000 Hz, two digits
// - floor is 40 Hz after reset
// - stored floor drives the sweep bottom output
// - sweep top fixed at 100 kHz
// - parser takes M/K scale and HZ unit
// - floor query answers in NR3 form
// - DC correction runs whatever the floor
// - load switch takes ON/1/OFF/0, answers 1/0
// - enabling load also enables open and short
// - open switch takes ON/1/OFF/0, answers 1/0
// - short switch takes ON/1/OFF/0, answers 1/0
// - two-term method turns load correction off
`timescale 1ns/1ps
`default_nettype none
`include "cs_cfg.svh"

module cs_corr_cmd (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // command request
   input wire logic cmd_start,
   input wire cs_pkg::cs_cmd_t cmd_sel,
   input wire cs_pkg::cs_char_t par,
   // command status
   output logic busy_ff,
   output logic done_ff,
   output logic cmd_err_ff,
   // answer characters
   input wire logic resp_ready,
   output var cs_pkg::cs_char_t resp_ff,
   // settings seen by the measurement side
   output var cs_pkg::cs_floor_t floor_ff,
   output logic [26:0] sweep_ceil_mhz_ff,
   output var cs_pkg::cs_sw_t sw_ff,
   output logic dc_corr_on_ff,
   output logic slow_sweep_ff
);

   typedef enum logic [1:0] {st_idle, st_args, st_wait, st_resp} cs_state_t;

   cs_state_t st_ff, nxt_st;
   cs_pkg::cs_cmd_t sel_ff, nxt_sel;
   logic [23:0] word_ff, nxt_word;
   logic [2:0] wcnt_ff, nxt_wcnt;
   logic [3:0] idx_ff, nxt_idx;
   cs_pkg::cs_floor_t nxt_floor;
   cs_pkg::cs_sw_t nxt_sw;
   cs_pkg::cs_char_t nxt_resp;
   logic nxt_busy, nxt_done, nxt_err, nxt_slow;
   logic [7:0] up_ch;
   logic word_on, word_off;
   logic [3:0] last_idx;

   // parser hookup: it only ever sees characters of a floor command
   logic p_start;
   cs_pkg::cs_char_t p_chr;
   logic p_done, p_err;
   cs_pkg::cs_floor_t p_res;

   assign p_start = cmd_start && (st_ff == st_idle) && (cmd_sel == cs_pkg::cmd_floor_set);
   assign p_chr = (st_ff == st_args && sel_ff == cs_pkg::cmd_floor_set) ? par : '0;

   cs_freq_parse u_parse (
      .mclk(mclk),
      .reset(reset),
      .start(p_start),
      .chr(p_chr),
      .done_ff(p_done),
      .err_ff(p_err),
      .res_ff(p_res)
   );

   // answer character at a position; a switch answer is a single 1 or 0
   function automatic logic [7:0] resp_char(input cs_pkg::cs_cmd_t sel, input logic [3:0] idx,
         input cs_pkg::cs_floor_t fl, input cs_pkg::cs_sw_t sw);
      logic bit_on;
      logic [3:0] mag;
      bit_on = (sel == cs_pkg::cmd_load_qry) ? sw.load_on :
               (sel == cs_pkg::cmd_open_qry) ? sw.open_on : sw.short_on;
      mag = fl.e10[3] ? (4'h0 - fl.e10) : fl.e10;
      resp_char = `CS_CH_ZERO;
      if (sel != cs_pkg::cmd_floor_qry) begin
         resp_char = bit_on ? `CS_CH_ONE : `CS_CH_ZERO;
      end else begin
         // +d.d0000E+0d, exponent never needs a second digit
         case (idx)
            4'h0: resp_char = `CS_CH_PLUS;
            4'h1: resp_char = {4'h3, fl.d1};
            4'h2: resp_char = `CS_CH_DOT;
            4'h3: resp_char = {4'h3, fl.d2};
            4'h8: resp_char = `CS_CH_E;
            4'h9: resp_char = fl.e10[3] ? `CS_CH_MINUS : `CS_CH_PLUS;
            4'hb: resp_char = {4'h3, mag};
            default: resp_char = `CS_CH_ZERO;
         endcase
      end
   endfunction : resp_char

   // command sequencing, switch words and answers
   always_comb begin
      nxt_st = st_ff;
      nxt_sel = sel_ff;
      nxt_word = word_ff;
      nxt_wcnt = wcnt_ff;
      nxt_idx = idx_ff;
      nxt_floor = floor_ff;
      nxt_sw = sw_ff;
      nxt_resp = resp_ff;
      nxt_done = 1'b0;
      nxt_err = 1'b0;
      up_ch = (par.data >= 8'h61 && par.data <= 8'h7a) ? par.data - 8'h20 : par.data;
      word_on = 1'b0;
      word_off = 1'b0;
      last_idx = (sel_ff == cs_pkg::cmd_floor_qry) ? `CS_NR3_LAST : 4'h0;
      case (st_ff)
         st_idle: begin
            if (cmd_start) begin
               nxt_sel = cmd_sel;
               nxt_word = 24'h000000;
               nxt_wcnt = 3'h0;
               nxt_idx = 4'h0;
               case (cmd_sel)
                  cs_pkg::cmd_floor_set, cs_pkg::cmd_load_set,
                  cs_pkg::cmd_open_set, cs_pkg::cmd_short_set: begin
                     nxt_st = st_args;
                  end
                  cs_pkg::cmd_floor_qry, cs_pkg::cmd_load_qry,
                  cs_pkg::cmd_open_qry, cs_pkg::cmd_short_qry: begin
                     // first character goes out on the next edge
                     nxt_resp.valid = 1'b1;
                     nxt_resp.last = (cmd_sel != cs_pkg::cmd_floor_qry);
                     nxt_resp.data = resp_char(cmd_sel, 4'h0, floor_ff, sw_ff);
                     nxt_st = st_resp;
                  end
                  cs_pkg::cmd_two_term: begin
                     nxt_sw.three_term = 1'b0;
                     nxt_sw.load_on = 1'b0;
                     nxt_done = 1'b1;
                  end
                  cs_pkg::cmd_three_term: begin
                     nxt_sw.three_term = 1'b1;
                     nxt_done = 1'b1;
                  end
                  default: begin
                     nxt_err = 1'b1;
                     nxt_done = 1'b1;
                  end
               endcase
            end
         end
         st_args: begin
            if (par.valid) begin
               if (sel_ff == cs_pkg::cmd_floor_set) begin
                  if (par.last) nxt_st = st_wait;
               end else begin
                  // keep the last three letters; the count saturates past them
                  if (up_ch != `CS_CH_SPACE) begin
                     nxt_word = {word_ff[15:0], up_ch};
                     nxt_wcnt = (wcnt_ff == 3'h4) ? wcnt_ff : wcnt_ff + 3'h1;
                  end
                  word_on = (nxt_wcnt == 3'h2 && nxt_word[15:0] == {`CS_CH_O, `CS_CH_N}) ||
                            (nxt_wcnt == 3'h1 && nxt_word[7:0] == `CS_CH_ONE);
                  word_off = (nxt_wcnt == 3'h3 && nxt_word == {`CS_CH_O, `CS_CH_F, `CS_CH_F}) ||
                             (nxt_wcnt == 3'h1 && nxt_word[7:0] == `CS_CH_ZERO);
                  if (par.last) begin
                     nxt_st = st_idle;
                     nxt_done = 1'b1;
                     nxt_err = !(word_on || word_off);
                     if (word_on || word_off) begin
                        case (sel_ff)
                           cs_pkg::cmd_load_set: begin
                              nxt_sw.load_on = word_on;
                              if (word_on) begin
                                 nxt_sw.open_on = 1'b1;
                                 nxt_sw.short_on = 1'b1;
                              end
                           end
                           cs_pkg::cmd_open_set: nxt_sw.open_on = word_on;
                           cs_pkg::cmd_short_set: nxt_sw.short_on = word_on;
                           default: nxt_err = 1'b1;
                        endcase
                     end
                  end
               end
            end
         end
         st_wait: begin
            if (p_done) begin
               nxt_st = st_idle;
               nxt_done = 1'b1;
               nxt_err = p_err;
               if (!p_err) nxt_floor = p_res;
            end
         end
         st_resp: begin
            if (resp_ready && resp_ff.valid) begin
               if (resp_ff.last) begin
                  nxt_resp = '0;
                  nxt_st = st_idle;
                  nxt_done = 1'b1;
               end else begin
                  nxt_idx = idx_ff + 4'h1;
                  nxt_resp.last = (nxt_idx == last_idx);
                  nxt_resp.data = resp_char(sel_ff, nxt_idx, floor_ff, sw_ff);
               end
            end
         end
         default: nxt_st = st_idle;
      endcase
      nxt_busy = (nxt_st != st_idle);
      nxt_slow = (nxt_floor.mhz <= `CS_SLOW_MHZ); // warns the host of long sweeps
   end

   // registers; the ceiling and DC enable only ever hold their reset constants
   always_ff @(posedge mclk) begin
      if (reset) begin
         st_ff <= st_idle;
         sel_ff <= cs_pkg::cmd_floor_qry;
         word_ff <= 24'h000000;
         wcnt_ff <= 3'h0;
         idx_ff <= 4'h0;
         floor_ff.mhz <= `CS_FLOOR_RST_MHZ;
         floor_ff.d1 <= `CS_FLOOR_RST_D1;
         floor_ff.d2 <= `CS_FLOOR_RST_D2;
         floor_ff.e10 <= `CS_FLOOR_RST_E10;
         sw_ff <= `CS_SW_RST;
         resp_ff <= '0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         cmd_err_ff <= 1'b0;
         slow_sweep_ff <= 1'b0;
         sweep_ceil_mhz_ff <= `CS_CEIL_MHZ;
         dc_corr_on_ff <= 1'b1;
      end else begin
         st_ff <= nxt_st;
         sel_ff <= nxt_sel;
         word_ff <= nxt_word;
         wcnt_ff <= nxt_wcnt;
         idx_ff <= nxt_idx;
         floor_ff <= nxt_floor; // sweep bottom follows the stored floor
         sw_ff <= nxt_sw;
         resp_ff <= nxt_resp;
         busy_ff <= nxt_busy;
         done_ff <= nxt_done;
         cmd_err_ff <= nxt_err;
         slow_sweep_ff <= nxt_slow;
      end
   end

   // checks on the settings and answers
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   floor_range_a: assert property (
      floor_ff.mhz >= 20'h00001 && floor_ff.mhz <= 20'hf4240)
      else $error("stored floor outside 1 mHz to 1000 Hz");

   floor_reset_a: assert property ($past(reset) |-> floor_ff.mhz == 20'h09c40)
      else $error("floor not 40 Hz after reset");

   floor_take_a: assert property (
      (st_ff == st_wait && p_done && !p_err) |=> (floor_ff == $past(p_res)) && cmd_err_ff == 1'b0)
      else $error("accepted floor not stored");

   ceil_fixed_a: assert property (sweep_ceil_mhz_ff == 27'h5f5e100)
      else $error("sweep top moved from 100 kHz");

   dc_always_a: assert property (dc_corr_on_ff && $stable(dc_corr_on_ff))
      else $error("dc correction dropped");

   nr3_shape_a: assert property (
      (resp_ff.valid && sel_ff == cs_pkg::cmd_floor_qry && idx_ff == 4'h2) |->
      resp_ff.data == 8'h2e && !resp_ff.last)
      else $error("floor answer not in NR3 shape");

   sw_answer_a: assert property (
      (resp_ff.valid && sel_ff != cs_pkg::cmd_floor_qry) |->
      resp_ff.last && (resp_ff.data == 8'h30 || resp_ff.data == 8'h31))
      else $error("switch answer not a single 1 or 0");

   load_couple_a: assert property ($rose(sw_ff.load_on) |-> sw_ff.open_on && sw_ff.short_on)
      else $error("load enabled without open and short");

   two_term_a: assert property (
      (st_ff == st_idle && cmd_start && cmd_sel == cs_pkg::cmd_two_term) |=> !sw_ff.load_on ##1 !busy_ff)
      else $error("two-term method left load on");

   reject_keep_a: assert property (
      (st_ff == st_wait && p_done && p_err) |=> $stable(floor_ff) && cmd_err_ff && done_ff)
      else $error("rejected floor changed the stored value");

   // an error is only ever reported as the command closes
   err_with_done_a: assert property (cmd_err_ff |-> done_ff && !busy_ff)
      else $error("command error without command end");

   floor_busy_a: assert property (
      (st_ff == st_idle && cmd_start && cmd_sel == cs_pkg::cmd_floor_set) |=> busy_ff)
      else $error("floor command not marked busy");

endmodule : cs_corr_cmd
`default_nettype wire

// [hdl/cs_cfg.svh]
// constants for the correction-settings command block: reset values, limits, characters
// assumes it is included by bare name wherever these macros are used
`ifndef CS_CFG_SVH
`define CS_CFG_SVH

// sweep floor after reset: 40 Hz, kept as mHz and as NR3 digits
`define CS_FLOOR_RST_MHZ 20'h09c40
`define CS_FLOOR_RST_D1 4'h4
`define CS_FLOOR_RST_D2 4'h0
`define CS_FLOOR_RST_E10 4'h1

// accepted floor range in mHz: 0.001 Hz to 1000 Hz
`define CS_FLOOR_MIN_MHZ 24'h000001
`define CS_FLOOR_MAX_MHZ 24'h0f4240

// fixed top of the sweep: 100 kHz in mHz
`define CS_CEIL_MHZ 27'h5f5e100

// floors at or below 1 Hz make the sweep slow
`define CS_SLOW_MHZ 20'h003e8

// switch state after reset: all off, open/short method
`define CS_SW_RST 4'h0

// significant digits kept while parsing, one more than stored for rounding
`define CS_SIG_KEEP 2'h3

// index of the last character of an NR3 answer, +d.dddddE+dd is 12 long
`define CS_NR3_LAST 4'hb

// character codes
`define CS_CH_SPACE 8'h20
`define CS_CH_PLUS 8'h2b
`define CS_CH_MINUS 8'h2d
`define CS_CH_DOT 8'h2e
`define CS_CH_ZERO 8'h30
`define CS_CH_ONE 8'h31
`define CS_CH_E 8'h45
`define CS_CH_F 8'h46
`define CS_CH_H 8'h48
`define CS_CH_K 8'h4b
`define CS_CH_M 8'h4d
`define CS_CH_N 8'h4e
`define CS_CH_O 8'h4f
`define CS_CH_Z 8'h5a

`endif

// [hdl/cs_pkg.sv]
// types shared by the correction-settings command block
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package cs_pkg;

   // command selected at the start of a command
   typedef enum logic [3:0] {
      cmd_floor_set,
      cmd_floor_qry,
      cmd_load_set,
      cmd_load_qry,
      cmd_open_set,
      cmd_open_qry,
      cmd_short_set,
      cmd_short_qry,
      cmd_two_term,
      cmd_three_term
   } cs_cmd_t;

   // one character of a parameter or of an answer
   typedef struct packed {
      logic valid;
      logic last;
      logic [7:0] data;
   } cs_char_t;

   // stored sweep floor: value in mHz plus its two digits and decimal exponent in Hz
   typedef struct packed {
      logic [19:0] mhz;
      logic [3:0] d1;
      logic [3:0] d2;
      logic [3:0] e10;
   } cs_floor_t;

   // correction switches
   typedef struct packed {
      logic open_on;
      logic short_on;
      logic load_on;
      logic three_term;
   } cs_sw_t;

endpackage : cs_pkg
`default_nettype wire

// [hdl/cs_freq_parse.sv]
// frequency parameter parser: digits, point, optional M/K scale, optional HZ unit
// assumes characters come from logic on mclk, one per cycle at most
`timescale 1ns/1ps
`default_nettype none
`include "cs_cfg.svh"

module cs_freq_parse (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // parameter characters
   input wire logic start,
   input wire cs_pkg::cs_char_t chr,
   // result
   output logic done_ff,
   output logic err_ff,
   output var cs_pkg::cs_floor_t res_ff
);

   typedef enum logic [3:0] {
      ps_idle, ps_num, ps_unit, ps_hz, ps_end, ps_round, ps_down, ps_up, ps_out
   } cs_pstate_t;

   cs_pstate_t st_ff, nxt_st;
   logic [9:0] mant_ff, nxt_mant;
   logic [1:0] nsig_ff, nxt_nsig;
   logic point_ff, nxt_point;
   logic any_ff, nxt_any;
   logic bad_ff, nxt_bad;
   logic signed [5:0] exp_ff, nxt_exp;
   logic [23:0] val_ff, nxt_val;
   logic nxt_done, nxt_err;
   cs_pkg::cs_floor_t nxt_res;
   logic [7:0] up;
   logic isdig;
   logic [9:0] rnd;

   // character classing and per-state stepping
   always_comb begin
      nxt_st = st_ff;
      nxt_mant = mant_ff;
      nxt_nsig = nsig_ff;
      nxt_point = point_ff;
      nxt_any = any_ff;
      nxt_bad = bad_ff;
      nxt_exp = exp_ff;
      nxt_val = val_ff;
      nxt_res = res_ff;
      nxt_done = 1'b0;
      nxt_err = 1'b0;
      up = (chr.data >= 8'h61 && chr.data <= 8'h7a) ? chr.data - 8'h20 : chr.data;
      isdig = (chr.data >= `CS_CH_ZERO) && (chr.data <= 8'h39);
      rnd = (mant_ff + 10'h005) / 10'h00a; // half-up rounding by one digit
      if (start) begin
         nxt_st = ps_num;
         nxt_mant = 10'h000;
         nxt_nsig = 2'h0;
         nxt_point = 1'b0;
         nxt_any = 1'b0;
         nxt_bad = 1'b0;
         nxt_exp = 6'sh00;
      end else if (chr.valid && (st_ff == ps_num || st_ff == ps_unit ||
                                 st_ff == ps_hz || st_ff == ps_end)) begin
         if (up == `CS_CH_SPACE) begin
            nxt_st = st_ff; // blanks are ignored anywhere
         end else if (st_ff == ps_num && isdig) begin
            nxt_any = 1'b1;
            if (mant_ff == 10'h000 && chr.data[3:0] == 4'h0) begin
               if (point_ff && exp_ff != 6'sh20) nxt_exp = exp_ff - 6'sh01;
            end else if (nsig_ff != `CS_SIG_KEEP) begin
               nxt_mant = 10'(mant_ff * 10'h00a + {6'h00, chr.data[3:0]});
               nxt_nsig = nsig_ff + 2'h1;
               if (point_ff) nxt_exp = exp_ff - 6'sh01;
            end else if (!point_ff && exp_ff != 6'sh1f) begin
               nxt_exp = exp_ff + 6'sh01; // digit beyond precision only scales
            end
         end else if (st_ff == ps_num && up == `CS_CH_DOT) begin
            nxt_bad = bad_ff | point_ff;
            nxt_point = 1'b1;
         end else if (st_ff == ps_num && up == `CS_CH_M) begin
            nxt_exp = exp_ff - 6'sh03;
            nxt_st = ps_unit;
         end else if (st_ff == ps_num && up == `CS_CH_K) begin
            nxt_exp = exp_ff + 6'sh03;
            nxt_st = ps_unit;
         end else if ((st_ff == ps_num || st_ff == ps_unit) && up == `CS_CH_H) begin
            nxt_st = ps_hz;
         end else if (st_ff == ps_hz && up == `CS_CH_Z) begin
            nxt_st = ps_end;
         end else begin
            nxt_bad = 1'b1;
         end
         if (chr.last) begin
            // a dangling H or no digit at all cannot be a value
            if (nxt_bad || !nxt_any || nxt_st == ps_hz) begin
               nxt_bad = 1'b1;
               nxt_st = ps_out;
            end else begin
               nxt_st = ps_round;
            end
         end
      end else begin
         case (st_ff)
            ps_round: begin
               // go to mHz and keep two significant digits
               if (mant_ff >= 10'h064) begin
                  nxt_mant = (rnd == 10'h064) ? 10'h00a : rnd;
                  nxt_exp = (rnd == 10'h064) ? exp_ff + 6'sh05 : exp_ff + 6'sh04;
               end else begin
                  nxt_exp = exp_ff + 6'sh03;
               end
               nxt_st = ps_down;
            end
            ps_down: begin
               if (exp_ff < 0) begin
                  nxt_mant = rnd; // below 10 mHz the step is 1 mHz
                  nxt_exp = exp_ff + 6'sh01;
               end else begin
                  nxt_val = {14'h0000, mant_ff};
                  nxt_res.d1 = (mant_ff >= 10'h00a) ? 4'(mant_ff / 10'h00a) : mant_ff[3:0];
                  nxt_res.d2 = (mant_ff >= 10'h00a) ? 4'(mant_ff % 10'h00a) : 4'h0;
                  nxt_res.e10 = (mant_ff >= 10'h00a) ? 4'(exp_ff - 6'sh02) :
                                4'(exp_ff - 6'sh03);
                  nxt_st = ps_up;
               end
            end
            ps_up: begin
               if (val_ff > `CS_FLOOR_MAX_MHZ) begin
                  nxt_bad = 1'b1; // stop early, the product would only grow
                  nxt_st = ps_out;
               end else if (exp_ff > 0) begin
                  nxt_val = 24'(val_ff * 24'h00000a);
                  nxt_exp = exp_ff - 6'sh01;
               end else begin
                  nxt_bad = (val_ff < `CS_FLOOR_MIN_MHZ);
                  nxt_res.mhz = val_ff[19:0];
                  nxt_st = ps_out;
               end
            end
            ps_out: begin
               nxt_done = 1'b1;
               nxt_err = bad_ff;
               nxt_st = ps_idle;
            end
            default: nxt_st = st_ff;
         endcase
      end
   end

   // state registers
   always_ff @(posedge mclk) begin
      if (reset) begin
         st_ff <= ps_idle;
         mant_ff <= 10'h000;
         nsig_ff <= 2'h0;
         point_ff <= 1'b0;
         any_ff <= 1'b0;
         bad_ff <= 1'b0;
         exp_ff <= 6'sh00;
         val_ff <= 24'h000000;
         res_ff <= '0;
         done_ff <= 1'b0;
         err_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         mant_ff <= nxt_mant;
         nsig_ff <= nxt_nsig;
         point_ff <= nxt_point;
         any_ff <= nxt_any;
         bad_ff <= nxt_bad;
         exp_ff <= nxt_exp;
         val_ff <= nxt_val;
         res_ff <= nxt_res;
         done_ff <= nxt_done;
         err_ff <= nxt_err;
      end
   end

   parse_bound_a: assert property (@(posedge mclk) disable iff (reset)
      (chr.valid && chr.last && st_ff == ps_num && !start) |-> ##[1:80] done_ff)
      else $error("parser gave no result after the last character");

endmodule : cs_freq_parse
`default_nettype wire

// [test/cs_host_model.sv]
// host-side answer receiver: takes answer chars, shifts them into a text word
// assumes resp comes from cs_corr_cmd on the same mclk
`timescale 1ns/1ps
`default_nettype none

module cs_host_model (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // pacing and answer stream
   input wire logic slow,
   input wire cs_pkg::cs_char_t resp,
   output logic resp_ready,
   output logic [95:0] text
);
   // slow host accepts every other cycle, so valid must hold through stalls
   always_ff @(posedge mclk) begin
      if (reset) begin
         resp_ready <= 1'b0;
         text <= '0;
      end else begin
         resp_ready <= slow ? ~resp_ready : 1'b1;
         if (resp.valid && resp_ready) text <= {text[87:0], resp.data};
      end
   end
endmodule : cs_host_model
`default_nettype wire

// [test/tb_top.sv]
// command-level bench for cs_corr_cmd with a host answer model
// assumes the design and cs_host_model compile before this file
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic mclk, reset, cmd_start, busy_ff, done_ff, cmd_err_ff, resp_ready, dc_corr_on_ff;
   logic slow_sweep_ff, slow;
   logic [26:0] sweep_ceil_mhz_ff;
   logic [95:0] text;
   cs_pkg::cs_cmd_t cmd_sel;
   cs_pkg::cs_char_t par, resp_ff;
   cs_pkg::cs_floor_t floor_ff;
   cs_pkg::cs_sw_t sw_ff;
   int errors = 0, tests_run = 0, cyc = 0, i;
   string fs[6] = '{"10", "1M", "1KHZ", "2.35 hz", "5.5M", "40"};
   logic [19:0] fm[6] = '{20'h02710, 20'h00001, 20'hf4240, 20'h00960, 20'h00006, 20'h09c40};
   logic [95:0] fq[6] = '{"+1.00000E+01", "+1.00000E-03", "+1.00000E+03", "+2.40000E+00",
      "+6.00000E-03", "+4.00000E+01"};
   string es[5] = '{"1100", "0.4M", "2KHZ", "ABC", "-5"};
   cs_pkg::cs_cmd_t ss[10] = '{cs_pkg::cmd_load_set, cs_pkg::cmd_open_set,
      cs_pkg::cmd_short_set, cs_pkg::cmd_load_set, cs_pkg::cmd_open_set, cs_pkg::cmd_short_set,
      cs_pkg::cmd_load_set, cs_pkg::cmd_two_term, cs_pkg::cmd_three_term, cs_pkg::cmd_load_set};
   string sv[10] = '{"ON", "OFF", "0", "OFF", "1", "on", "1", "", "", "ONN"};
   logic [3:0] sx[10] = '{4'he, 4'h6, 4'h2, 4'h0, 4'h8, 4'hc, 4'he, 4'hc, 4'hd, 4'hd};

   cs_corr_cmd uut (.mclk(mclk), .reset(reset), .cmd_start(cmd_start), .cmd_sel(cmd_sel),
      .par(par), .busy_ff(busy_ff), .done_ff(done_ff), .cmd_err_ff(cmd_err_ff),
      .resp_ready(resp_ready), .resp_ff(resp_ff), .floor_ff(floor_ff),
      .sweep_ceil_mhz_ff(sweep_ceil_mhz_ff), .sw_ff(sw_ff), .dc_corr_on_ff(dc_corr_on_ff),
      .slow_sweep_ff(slow_sweep_ff));
   cs_host_model host (.mclk(mclk), .reset(reset), .slow(slow), .resp(resp_ff),
      .resp_ready(resp_ready), .text(text));

   // one compare for every kind of result, widened to the answer text width
   task automatic chk(logic [95:0] g, logic [95:0] x);
      tests_run++;
      if (g !== x) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, x);
      end
   endtask : chk

   // start, send the word one char per cycle, wait bounded for done
   task automatic run(cs_pkg::cs_cmd_t c, string s, logic e);
      int k;
      @(posedge mclk);
      cmd_sel <= c;
      cmd_start <= 1'b1;
      @(posedge mclk);
      cmd_start <= 1'b0;
      for (k = 0; k < s.len(); k++) begin
         par <= cs_pkg::cs_char_t'({1'b1, k == s.len() - 1, s[k]});
         @(posedge mclk);
      end
      par <= '0;
      k = 0;
      // done stands one cycle and may follow the edge just passed, so look there first
      #1;
      while (done_ff !== 1'b1 && k < 120) begin
         @(posedge mclk);
         #1;
         k++;
      end
      chk({done_ff, cmd_err_ff, busy_ff}, {1'b1, e, 1'b0});
   endtask : run

   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : give_verdict

   // clock and hang guard, the whole run needs well under a thousand cycles
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         give_verdict();
      end
   end

   initial begin
      reset = 1'b1;
      cmd_start = 1'b0;
      cmd_sel = cs_pkg::cmd_floor_qry;
      par = '0;
      slow = 1'b1;
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      #1;
      chk(floor_ff, {20'h09c40, 4'h4, 4'h0, 4'h1});
      chk({sweep_ceil_mhz_ff, dc_corr_on_ff, slow_sweep_ff}, {27'h5f5e100, 2'h2});
      chk(sw_ff, 4'h0);
      run(cs_pkg::cmd_floor_qry, "", 1'b0);
      chk(text, "+4.00000E+01");
      $display("test reset values done");
      // scale, unit, rounding and the answer form, host stalling
      for (i = 0; i < 6; i++) begin
         run(cs_pkg::cmd_floor_set, fs[i], 1'b0);
         chk({floor_ff.mhz, slow_sweep_ff}, {fm[i], fm[i] <= 20'h003e8});
         chk(sweep_ceil_mhz_ff, 27'h5f5e100);
         run(cs_pkg::cmd_floor_qry, "", 1'b0);
         chk(text, fq[i]);
      end
      $display("test floor set done");
      // refused floors keep the stored 40 Hz
      for (i = 0; i < 5; i++) begin
         run(cs_pkg::cmd_floor_set, es[i], 1'b1);
         chk(floor_ff.mhz, 20'h09c40);
      end
      run(cs_pkg::cs_cmd_t'(4'hf), "", 1'b1);
      chk(floor_ff.mhz, 20'h09c40);
      $display("test floor refuse done");
      slow <= 1'b0;
      // switch words, load coupling and the two methods
      for (i = 0; i < 10; i++) begin
         run(ss[i], sv[i], i == 9);
         chk(sw_ff, sx[i]);
         run(cs_pkg::cmd_load_qry, "", 1'b0);
         chk(text[7:0], {7'h18, sx[i][1]});
         run(cs_pkg::cmd_open_qry, "", 1'b0);
         chk(text[7:0], {7'h18, sx[i][3]});
         run(cs_pkg::cmd_short_qry, "", 1'b0);
         chk(text[7:0], {7'h18, sx[i][2]});
      end
      $display("test switches done");
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
